// ===== serial_comm_defs.svh
// register offsets, field positions, reset values and timing counts for the serial interface
`ifndef SERIAL_COMM_DEFS_SVH
`define SERIAL_COMM_DEFS_SVH
`define OFS_STATUS_ONE 8'h11
`define OFS_RATE_MODE 8'h10
`define OFS_TRANSMIT_DATA 8'h13
`define OFS_RECEIVE_DATA 8'h12
`define OFS_STATUS_TWO 8'h1e
`define OFS_TIMER_TWO 8'h1c
`define RST_STATUS_ONE 8'h20
`define BIT_WAKE 0
`define BIT_TX_EN 1
`define BIT_TX_IE 2
`define BIT_RX_EN 3
`define BIT_RX_IE 4
`define BIT_TX_EMPTY 5
`define BIT_OVR_FRM 6
`define BIT_RX_FULL 7
`define BIT_PAR_ERR 4
`define DIV_ASYNC_0 16'd16
`define DIV_ASYNC_1 16'd128
`define DIV_ASYNC_2 16'd1024
`define DIV_ASYNC_3 16'd4096
`define DIV_SYNC_0 16'd2
`define DIV_SYNC_1 16'd16
`define DIV_SYNC_2 16'd128
`define DIV_SYNC_3 16'd512
`define OVERSAMPLE 5'd16
`define E_PRESCALE 8'd4
`endif

// ===== serial_comm_interface_regs.sv
// serial communication interface: register file, transmitter and receiver
// Functional notes
// - wake-up: skip data until one idle frame
// - transmit enable drives data pin, preamble async
// - transmit empty with enable raises interrupt
// - receive enable takes input from data pin
// - receive full or error with enable interrupts
// - transmit empty set on load/empty, reset
// - transmit empty clears: status read, data write
// - error flag on overrun or zero stop
// - error flag clears: status read, data read
// - receive full set on clean transfer
// - receive full clears: status read, data read
// - async rate from E over 16..4096
// - sync internal rate E over 2..512
// - speed bit2 uses timer two constant
// - clock control selects mode, format, clock pin
// - reset clears rate/mode bits zero to five
// - stop length: one or two stop bits
// - parity select: even zero, odd one
// - parity only in async mode
// - parity error set on mismatch, cleared by read
// - status one reads 0x20 after reset
`include "serial_comm_defs.svh"
module serial_comm_interface_regs (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_data_in,
  input wire logic clk_pin_in,
  output logic tx_data_out,
  output logic tx_data_oe,
  output logic clk_pin_out,
  output logic clk_pin_oe,
  output logic serial_irq
);
  import serial_comm_pkg::*;

  // software-visible state
  logic wake_up_bit, transmit_enable, transmit_interrupt_enable, receive_enable, receive_interrupt_enable;
  logic transmit_empty_flag, overrun_framing_flag, receive_full_flag, parity_error_flag;
  logic stop_length, parity_select, parity_enable;
  logic [5:0] rate_mode_register; // speed bits 0,1,5 packed as {ss2,cc2,cc1,cc0,ss1,ss0}
  byte_t transmit_data_register, receive_data_register, timer_two_constant;
  logic status_read_armed; // a status read happened, for the clear sequences
  logic status_two_armed; // status two read, for parity error clear
  logic tx_empty_seen; // flag was one at the status read
  logic ack_pending; // one wait cycle on every access

  // pin synchronisers
  logic [1:0] rx_sync, clk_sync;
  logic clk_prev;
  always_ff @(posedge core_clk) begin
    rx_sync <= {rx_sync[0], rx_data_in};
    clk_sync <= {clk_sync[0], clk_pin_in};
    clk_prev <= clk_sync[1];
  end

  // decoded mode
  logic speed_select_bit0, speed_select_bit1, speed_select_bit2;
  logic clock_control_bit0, clock_control_bit1, clock_control_bit2;
  assign speed_select_bit0 = rate_mode_register[0];
  assign speed_select_bit1 = rate_mode_register[1];
  assign clock_control_bit0 = rate_mode_register[2];
  assign clock_control_bit1 = rate_mode_register[3];
  assign clock_control_bit2 = rate_mode_register[4];
  assign speed_select_bit2 = rate_mode_register[5];
  clock_mode_t clock_mode;
  logic sync_mode, sync_internal, seven_bit;
  assign clock_mode = clock_mode_t'({clock_control_bit1, clock_control_bit0});
  assign sync_mode = (clock_mode == fmt_sync);
  assign sync_internal = sync_mode && clock_control_bit2;
  assign seven_bit = clock_control_bit2 && !sync_mode;

  // E clock enable: system clock E derived by a fixed prescale of core_clk
  logic [7:0] e_count;
  logic e_tick;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      e_count <= 8'h00;
      e_tick <= 1'b0;
    end else begin
      e_tick <= (e_count == `E_PRESCALE - 8'd1);
      e_count <= (e_count == `E_PRESCALE - 8'd1) ? 8'h00 : e_count + 8'd1;
    end
  end

  // divider selection, used by both the async and sync paths
  // code[2] is the timer-two select; passed in so the caller's assign sees every input change
  function automatic logic [15:0] pick_divider(input logic sync, input logic [2:0] code, input byte_t n);
    logic [15:0] d;
    d = 16'd0;
    if (code[2]) begin
      d = sync ? {6'h00, n, 2'b00} + 16'd4 : {3'h0, n, 5'h00} + 16'd32;
    end else begin
      case (code[1:0])
        2'd0: d = sync ? `DIV_SYNC_0 : `DIV_ASYNC_0;
        2'd1: d = sync ? `DIV_SYNC_1 : `DIV_ASYNC_1;
        2'd2: d = sync ? `DIV_SYNC_2 : `DIV_ASYNC_2;
        default: d = sync ? `DIV_SYNC_3 : `DIV_ASYNC_3;
      endcase
    end
    return d;
  endfunction

  // internal bit-rate divider: async gives one 16x tick per div/16 E cycles
  logic [15:0] div_count, div_limit;
  logic rate_tick;
  assign div_limit = pick_divider(sync_mode, {speed_select_bit2, speed_select_bit1, speed_select_bit0},
                                  timer_two_constant);
  always_ff @(posedge core_clk) begin
    if (reset) begin
      div_count <= 16'h0000;
      rate_tick <= 1'b0;
    end else begin
      rate_tick <= 1'b0;
      if (e_tick) begin
        if (div_count >= (sync_mode ? (div_limit >> 1) : (div_limit >> 4)) - 16'd1) begin
          div_count <= 16'h0000;
          rate_tick <= 1'b1;
        end else begin
          div_count <= div_count + 16'd1;
        end
      end
    end
  end

  // clock toggle for output pin; external edges on the synced pin
  logic int_clk, ext_rise, ext_fall, clk_rise, clk_fall, sample16;
  assign ext_rise = clk_sync[1] && !clk_prev;
  assign ext_fall = !clk_sync[1] && clk_prev;
  assign sample16 = (clock_mode == fmt_async_ext) ? ext_rise : rate_tick; // 16x in async
  logic sync_active; // internal sync clock runs only while a byte is sent or while receive is enabled and not full
  always_ff @(posedge core_clk) begin
    if (reset || !sync_active) begin
      int_clk <= 1'b1;
    end else if (rate_tick) begin
      int_clk <= !int_clk;
    end
  end
  assign clk_rise = sync_internal ? (rate_tick && !int_clk && sync_active) : ext_rise;
  assign clk_fall = sync_internal ? (rate_tick && int_clk && sync_active) : ext_fall;

  // pin drive, clock pin per mode
  always_ff @(posedge core_clk) begin
    if (reset) begin
      clk_pin_out <= 1'b1;
      clk_pin_oe <= 1'b0;
    end else begin
      clk_pin_oe <= sync_internal || (clock_mode == fmt_async_out);
      clk_pin_out <= sync_mode ? int_clk : (rate_tick ? !clk_pin_out : clk_pin_out);
    end
  end

  // transmitter
  logic [10:0] tx_shift;
  logic [3:0] tx_bits, tx_sub;
  logic tx_busy, tx_preamble, tx_load;
  logic tx_primed; // async preamble started since transmit enable
  logic tx_write, rx_read, stat_read;
  logic [3:0] frame_len;
  assign frame_len = 4'd9 + (seven_bit ? 4'd0 : 4'd1) + {3'd0, parity_enable} + {3'd0, stop_length} - 4'd1;
  assign sync_active = sync_internal && (tx_busy || (receive_enable && !receive_full_flag));
  // async load only off a sample tick, so the empty flag is set exactly when the load happens
  assign tx_load = transmit_enable && !transmit_empty_flag && !tx_busy && !tx_preamble &&
                   (sync_mode || (tx_primed && !sample16));
  always_ff @(posedge core_clk) begin
    if (reset || !transmit_enable) begin
      tx_busy <= 1'b0;
      tx_preamble <= 1'b0;
      tx_shift <= 11'h7ff;
      tx_bits <= 4'd0;
      tx_sub <= 4'd0;
      tx_primed <= 1'b0;
    end else if (!sync_mode && !tx_primed && !tx_preamble) begin
      tx_preamble <= 1'b1;
      tx_primed <= 1'b1; // one preamble per enable, not per byte
      tx_bits <= frame_len + 4'd1; // a full frame of ones
    end else if (sync_mode) begin
      if (tx_load) begin
        tx_busy <= 1'b1;
        tx_shift <= {3'b111, transmit_data_register};
        tx_bits <= 4'd8;
      end else if (tx_busy && clk_fall && tx_bits != 4'd0) begin
        if (tx_bits != 4'd8) tx_shift <= {1'b1, tx_shift[10:1]};
        tx_bits <= tx_bits - 4'd1;
      end else if (tx_busy && clk_rise && tx_bits == 4'd0) begin
        tx_busy <= 1'b0; // last bit held until its rising edge has passed
      end
    end else if (sample16) begin
      tx_sub <= tx_sub + 4'd1;
      if (tx_sub == 4'd15) begin
        if (tx_preamble || tx_busy) begin
          tx_shift <= {1'b1, tx_shift[10:1]};
          tx_bits <= tx_bits - 4'd1;
          if (tx_bits == 4'd1) begin
            tx_preamble <= 1'b0;
            tx_busy <= 1'b0;
          end
        end
      end
    end else if (tx_load) begin
      tx_busy <= 1'b1;
      tx_sub <= 4'd0;
      tx_bits <= frame_len + 4'd1;
      tx_shift <= seven_bit ?
        {2'b11, parity_enable ? ^{parity_select, transmit_data_register[6:0]} : 1'b1, transmit_data_register[6:0], 1'b0} :
        {1'b1, parity_enable ? ^{parity_select, transmit_data_register} : 1'b1, transmit_data_register, 1'b0};
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_data_out <= 1'b1;
      tx_data_oe <= 1'b0;
    end else begin
      tx_data_oe <= transmit_enable;
      tx_data_out <= (tx_busy && !(sync_mode && tx_bits == 4'd8)) ? tx_shift[0] : 1'b1;
    end
  end

  // receiver
  logic [9:0] rx_shift;
  logic [3:0] rx_bits, rx_sub;
  logic rx_busy, rx_done, rx_line;
  logic [7:0] rx_byte;
  logic rx_par_bad, rx_frm_bad;
  assign rx_line = receive_enable ? rx_sync[1] : 1'b1;
  always_ff @(posedge core_clk) begin
    if (reset || !receive_enable) begin
      rx_busy <= 1'b0;
      rx_done <= 1'b0;
      rx_shift <= 10'h000;
      rx_bits <= 4'd0;
      rx_sub <= 4'd0;
    end else begin
      rx_done <= 1'b0;
      if (sync_mode) begin
        if (!receive_full_flag && clk_rise) begin
          rx_shift <= {rx_line, rx_shift[9:1]};
          rx_bits <= rx_bits + 4'd1;
          if (rx_bits == 4'd7) begin
            rx_done <= 1'b1;
            rx_bits <= 4'd0;
          end
        end
      end else if (sample16) begin
        if (!rx_busy) begin
          rx_sub <= rx_line ? 4'd0 : rx_sub + 4'd1;
          if (!rx_line && rx_sub == 4'd7 && !wake_up_bit) begin
            rx_busy <= 1'b1;
            rx_sub <= 4'd0;
            rx_bits <= 4'd0;
          end
        end else begin
          rx_sub <= rx_sub + 4'd1;
          if (rx_sub == 4'd15) begin
            rx_shift <= {rx_line, rx_shift[9:1]};
            rx_bits <= rx_bits + 4'd1;
            if (rx_bits == frame_len - {3'd0, stop_length} - 4'd1) begin
              rx_busy <= 1'b0;
              rx_done <= 1'b1;
            end
          end
        end
      end
    end
  end
  // idle-frame detector for wake-up, counted in 16x sample ticks of ones
  logic [7:0] idle_count;
  logic wake_seen;
  always_ff @(posedge core_clk) begin
    if (reset || !wake_up_bit || !rx_line) begin
      idle_count <= 8'h00;
      wake_seen <= 1'b0;
    end else if (sample16) begin
      idle_count <= idle_count + 8'd1;
      wake_seen <= (idle_count == {frame_len + 4'd1, 4'h0});
    end
  end
  // unpack the frame into data, parity and stop
  logic [9:0] frame_aligned;
  assign frame_aligned = seven_bit ? (parity_enable ? {1'b0, rx_shift[9:1]} : {2'b00, rx_shift[9:2]})
                                   : (parity_enable ? rx_shift : {1'b0, rx_shift[9:1]});
  assign rx_byte = sync_mode ? rx_shift[9:2] : (seven_bit ? {1'b0, frame_aligned[6:0]} : frame_aligned[7:0]);
  assign rx_frm_bad = !sync_mode && !rx_shift[9];
  assign rx_par_bad = !sync_mode && parity_enable &&
    ((seven_bit ? ^{parity_select, frame_aligned[6:0]} : ^{parity_select, frame_aligned[7:0]})
     != (seven_bit ? frame_aligned[7] : frame_aligned[8]));

  // bus slave with one wait cycle
  logic access;
  assign access = (avs_read || avs_write) && !ack_pending;
  assign stat_read = avs_read && ack_pending && (avs_address == `OFS_STATUS_ONE || avs_address == `OFS_STATUS_TWO);
  assign tx_write = avs_write && ack_pending && avs_address == `OFS_TRANSMIT_DATA;
  assign rx_read = avs_read && ack_pending && avs_address == `OFS_RECEIVE_DATA;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_pending <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_pending <= access;
      avs_waitrequest <= !access;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      avs_readdata <= 32'h00000000;
    end else if (access) begin
      case (avs_address)
        `OFS_STATUS_ONE: avs_readdata <= {24'h0, receive_full_flag, overrun_framing_flag, transmit_empty_flag,
          receive_interrupt_enable, receive_enable, transmit_interrupt_enable, transmit_enable, wake_up_bit};
        `OFS_STATUS_TWO: avs_readdata <= {24'h0, receive_full_flag, overrun_framing_flag, transmit_empty_flag,
          parity_error_flag, 1'b0, parity_enable, parity_select, stop_length};
        `OFS_RATE_MODE: avs_readdata <= {26'h0, rate_mode_register};
        `OFS_RECEIVE_DATA: avs_readdata <= {24'h0, receive_data_register};
        `OFS_TRANSMIT_DATA: avs_readdata <= {24'h0, transmit_data_register};
        `OFS_TIMER_TWO: avs_readdata <= {24'h0, timer_two_constant};
        default: avs_readdata <= 32'h00000000; // unmapped reads zero
      endcase
    end
  end

  // writable control bits
  always_ff @(posedge core_clk) begin
    if (reset) begin
      {receive_interrupt_enable, receive_enable, transmit_interrupt_enable, transmit_enable} <= 4'h0;
      {parity_enable, parity_select, stop_length} <= 3'h0;
      rate_mode_register <= 6'h00;
      transmit_data_register <= 8'h00;
      timer_two_constant <= 8'h00;
    end else if (avs_write && ack_pending) begin
      case (avs_address)
        `OFS_STATUS_ONE: {receive_interrupt_enable, receive_enable, transmit_interrupt_enable, transmit_enable}
          <= avs_writedata[4:1];
        `OFS_STATUS_TWO: {parity_enable, parity_select, stop_length} <= avs_writedata[2:0];
        `OFS_RATE_MODE: rate_mode_register <= avs_writedata[5:0];
        `OFS_TRANSMIT_DATA: transmit_data_register <= avs_writedata[7:0];
        `OFS_TIMER_TWO: timer_two_constant <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // wake-up bit: software sets, idle frame clears
  always_ff @(posedge core_clk) begin
    if (reset) wake_up_bit <= 1'b0;
    else if (wake_seen) wake_up_bit <= 1'b0;
    else if (avs_write && ack_pending && avs_address == `OFS_STATUS_ONE) wake_up_bit <= avs_writedata[0];
  end

  // arm flags for read-then-access clear sequences
  always_ff @(posedge core_clk) begin
    if (reset) begin
      status_read_armed <= 1'b0;
      status_two_armed <= 1'b0;
      tx_empty_seen <= 1'b0;
    end else if (stat_read) begin
      status_read_armed <= receive_full_flag || overrun_framing_flag;
      status_two_armed <= parity_error_flag && avs_address == `OFS_STATUS_TWO;
      tx_empty_seen <= transmit_empty_flag;
    end else begin
      if (rx_read) status_read_armed <= 1'b0;
      if (rx_read) status_two_armed <= 1'b0;
      if (tx_write) tx_empty_seen <= 1'b0;
    end
  end

  // transmit empty flag; set beats clear
  always_ff @(posedge core_clk) begin
    if (reset) transmit_empty_flag <= 1'b1;
    else if ((!sync_mode && tx_load) || (sync_mode && tx_busy && clk_rise && tx_bits == 4'd0))
      transmit_empty_flag <= 1'b1;
    else if (tx_write && tx_empty_seen) transmit_empty_flag <= 1'b0;
  end

  // receive flags and data register; a new event wins over a clear
  logic rx_clear;
  assign rx_clear = rx_read && status_read_armed;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      receive_full_flag <= 1'b0;
      overrun_framing_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      receive_data_register <= 8'h00;
    end else begin
      if (rx_done && receive_full_flag && !sync_mode) overrun_framing_flag <= 1'b1;
      else if (rx_done && !receive_full_flag && rx_frm_bad) overrun_framing_flag <= 1'b1;
      else if (rx_clear) overrun_framing_flag <= 1'b0;
      if (rx_done && !receive_full_flag && !rx_frm_bad && !rx_par_bad) receive_full_flag <= 1'b1;
      else if (rx_clear) receive_full_flag <= 1'b0;
      if (rx_done && !receive_full_flag && rx_par_bad) parity_error_flag <= 1'b1;
      else if (rx_read && status_two_armed) parity_error_flag <= 1'b0;
      if (rx_done && !receive_full_flag) receive_data_register <= rx_byte;
    end
  end

  // single interrupt request
  always_ff @(posedge core_clk) begin
    if (reset) serial_irq <= 1'b0;
    else serial_irq <= (transmit_interrupt_enable && transmit_empty_flag) ||
                       (receive_interrupt_enable && (receive_full_flag || overrun_framing_flag));
  end
endmodule

// ===== serial_comm_interface_regs_assertions.sv
// concurrent checks on the serial interface ports
module serial_comm_interface_regs_assertions (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rx_data_in,
  input wire logic clk_pin_in,
  input wire logic tx_data_out,
  input wire logic tx_data_oe,
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe,
  input wire logic serial_irq
);
  logic ack; // access completes this cycle
  logic tdr_done, rm_done, two_done, one_done; // writes seen since reset
  logic [4:1] one_val; // last control bits written
  logic [2:0] rm_cc; // last clock code written
  logic irq_exp; // request implied by the status byte read
  assign ack = (avs_read | avs_write) & ~avs_waitrequest;
  assign irq_exp = (avs_readdata[2] & avs_readdata[5]) | (avs_readdata[4] & (avs_readdata[7] | avs_readdata[6]));
  // history of software writes since reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tdr_done <= 1'b0;
      rm_done <= 1'b0;
      two_done <= 1'b0;
      one_done <= 1'b0;
      one_val <= 4'h0;
      rm_cc <= 3'h0;
    end else if (ack && avs_write) begin
      if (avs_address == 8'h13) tdr_done <= 1'b1;
      if (avs_address == 8'h10) begin
        rm_done <= 1'b1;
        rm_cc <= avs_writedata[4:2];
      end
      if (avs_address == 8'h1e) two_done <= 1'b1;
      if (avs_address == 8'h11) begin
        one_done <= 1'b1;
        one_val <= avs_writedata[4:1];
      end
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence rd_s(a);
    ack && avs_read && avs_address == a;
  endsequence
  sequence wr_s(a);
    ack && avs_write && avs_address == a;
  endsequence
  sequence rdst_s;
    ack && avs_read && (avs_address == 8'h11 || avs_address == 8'h1e);
  endsequence
  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  te_pin_a: assert property (wr_s(8'h11) |=> ##[0:1] tx_data_oe == one_val[1])
    else $error("data pin enable does not follow transmit enable");
  clk_pin_a: assert property (wr_s(8'h10) |=> ##[0:1] clk_pin_oe == (rm_cc == 3'b100 || rm_cc[1:0] == 2'b10))
    else $error("clock pin enable wrong for clock code");
  irq_or_a: assert property (rd_s(8'h11) |-> ##[0:2] serial_irq == irq_exp)
    else $error("interrupt does not match status and enables");
  tx_empty_a: assert property (rdst_s |-> avs_readdata[5] || tdr_done)
    else $error("transmit empty low with no data written");
  ctl_write_a: assert property (rd_s(8'h11) ##0 one_done |-> avs_readdata[4:1] == one_val)
    else $error("control bits differ from last write");
  rate_reset_a: assert property (rd_s(8'h10) ##0 !rm_done |-> avs_readdata[5:0] == 6'h00)
    else $error("rate mode bits not clear after reset");
  fmt_reset_a: assert property (rd_s(8'h1e) ##0 !two_done |-> avs_readdata[2:0] == 3'h0)
    else $error("format bits not clear after reset");
endmodule
bind serial_comm_interface_regs serial_comm_interface_regs_assertions chk (.core_clk(core_clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_data_in(rx_data_in),
  .clk_pin_in(clk_pin_in), .tx_data_out(tx_data_out), .tx_data_oe(tx_data_oe), .clk_pin_out(clk_pin_out),
  .clk_pin_oe(clk_pin_oe), .serial_irq(serial_irq));

// ===== serial_comm_interface_regs_tb.sv
// self-checking bench for the serial interface registers
module serial_comm_interface_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import serial_comm_pkg::*;
  logic core_clk, reset, avs_read, avs_write, loop;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic avs_waitrequest, rx_data_in, clk_pin_in, tx_data_out, tx_data_oe, clk_pin_out, clk_pin_oe, serial_irq;
  int n_fail = 0;
  int tests_run = 0;
  byte_t q, got; // last read byte, byte caught by the peer
  serial_comm_interface_regs DUT (.core_clk(core_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_data_in(rx_data_in), .clk_pin_in(clk_pin_in),
    .tx_data_out(tx_data_out), .tx_data_oe(tx_data_oe), .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
    .serial_irq(serial_irq));
  serial_peer peer (.loop(loop), .tx_data_out(tx_data_out), .tx_data_oe(tx_data_oe), .clk_pin_out(clk_pin_out),
    .clk_pin_oe(clk_pin_oe), .rx_data_in(rx_data_in), .clk_pin_in(clk_pin_in));
  // 200 MHz system clock
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic complete_run();
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic pin(input string what, input logic seen, input logic exp);
    check(what, {7'h0, seen}, {7'h0, exp});
  endtask
  // one access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= ~wr;
    avs_write <= wr;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 40);
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      complete_run();
    end
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check(what, q, exp);
  endtask
  // poll a status bit; a flag that never comes is a failure
  task automatic wait_bit(input logic [7:0] a, input int b);
    int i;
    i = 0;
    do begin
      rd(a);
      i++;
    end while (q[b] !== 1'b1 && i < 8000);
    if (q[b] !== 1'b1) begin
      n_fail++;
      complete_run();
    end
  endtask
  initial begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    loop = 1'b0;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    rdc("status one", 8'h11, 8'h20);
    rd(8'h10);
    check("rate mode", q & 8'h3f, 8'h00);
    rdc("status two", 8'h1e, 8'h20);
    pin("clk oe", clk_pin_oe, 1'b0);
    pin("clk out", clk_pin_out, 1'b1);
    pin("tx oe", tx_data_oe, 1'b0);
    // interrupt enables against the reset-set empty flag
    wr(8'h11, 8'h14);
    rdc("status one", 8'h11, 8'h34);
    pin("irq", serial_irq, 1'b1);
    wr(8'h11, 8'hf0);
    rdc("status one", 8'h11, 8'h30);
    pin("irq", serial_irq, 1'b0);
    rdc("unmapped", 8'h05, 8'h00);
    // clocked transmit on the external clock
    wr(8'h11, 8'h02);
    rdc("status one", 8'h11, 8'h22);
    pin("tx oe", tx_data_oe, 1'b1);
    wr(8'h13, 8'ha5);
    rdc("status one", 8'h11, 8'h02);
    peer.frame(8'h00, got);
    check("sent byte", got, 8'ha5);
    rdc("status one", 8'h11, 8'h22);
    wr(8'h11, 8'h00);
    rd(8'h10);
    pin("tx oe", tx_data_oe, 1'b0);
    // clocked receive with its interrupt
    wr(8'h11, 8'h18);
    peer.frame(8'h3c, got);
    rdc("status one", 8'h11, 8'hb8);
    pin("irq", serial_irq, 1'b1);
    rdc("rx data", 8'h12, 8'h3c);
    rdc("status one", 8'h11, 8'h38);
    pin("irq", serial_irq, 1'b0);
    wr(8'h11, 8'h00);
    // every clock code and its pin direction
    for (int c = 0; c < 8; c++) begin
      wr(8'h10, {3'b000, c[2:0], 2'b11});
      rdc("rate mode", 8'h10, {3'b000, c[2:0], 2'b11});
      pin("clk oe", clk_pin_oe, c == 4 || c[1:0] == 2'b10);
    end
    // async, odd parity, two stops, looped back
    wr(8'h10, 8'h04);
    wr(8'h1e, 8'h07);
    rdc("status two", 8'h1e, 8'h27);
    loop <= 1'b1;
    wr(8'h11, 8'h0a);
    rd(8'h11);
    wr(8'h13, 8'h5a);
    wait_bit(8'h1e, 7);
    check("status two", q, 8'ha7);
    rdc("rx data", 8'h12, 8'h5a);
    rd(8'h11);
    wr(8'h13, 8'h11);
    wait_bit(8'h11, 7);
    wr(8'h13, 8'h22);
    wait_bit(8'h11, 6);
    check("error flags", q & 8'hc0, 8'hc0);
    rd(8'h12);
    rd(8'h11);
    check("error flags", q & 8'hc0, 8'h00);
    // wake-up with receive already on; the idle looped line clears it after one frame
    wr(8'h11, 8'h0b);
    rdc("status one", 8'h11, 8'h2b);
    repeat (1000) @(posedge core_clk);
    rdc("status one", 8'h11, 8'h2a);
    complete_run();
  end
endmodule

// ===== serial_comm_pkg.sv
// types shared by the serial interface
package serial_comm_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {fmt_sync, fmt_async_int, fmt_async_out, fmt_async_ext} clock_mode_t;
endpackage

// ===== serial_peer.sv
// far-side serial peer: clocked byte frames and an async loopback
module serial_peer (
  input wire logic loop,
  input wire logic tx_data_out,
  input wire logic tx_data_oe,
  input wire logic clk_pin_out,
  input wire logic clk_pin_oe,
  output logic rx_data_in,
  output logic clk_pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic link_clk = 1'b1; // stands high between frames
  logic rx_bit = 1'b1; // data the peer puts on the line
  // shared clock wire: the block wins while it drives
  assign clk_pin_in = clk_pin_oe ? clk_pin_out : link_clk;
  // loopback lets async tests check framing without a rate guess
  assign rx_data_in = loop ? tx_data_out : rx_bit;
  // eight pulses at 125 ns, well under half the system clock
  task automatic frame(input logic [7:0] d, output logic [7:0] r);
    for (int i = 0; i < 8; i++) begin
      #62.5 link_clk = 1'b0;
      rx_bit = d[i]; // new bit after the falling edge
      #62.5 link_clk = 1'b1;
      r[i] = tx_data_out; // taken at the rising edge
    end
    #62.5 rx_bit = ~d[7]; // released line no longer shows the bit
  endtask
endmodule
